// file: hdl/cpr_pkg.sv
// constants and carrier types for the core plane register bank
package cpr_pkg;
    localparam int ADDR_W = 9;
    // register indices; byte address is four times the index
    localparam logic [6:0] IDX_WINDOW = 7'h00;
    localparam logic [6:0] IDX_TIMER0 = 7'h01;
    localparam logic [6:0] IDX_PCL = 7'h02;
    localparam logic [6:0] IDX_FLAGS = 7'h03;
    localparam logic [6:0] IDX_POINTER = 7'h04;
    localparam logic [6:0] IDX_PORTA = 7'h05;
    localparam logic [6:0] IDX_IRQ_EN = 7'h08;
    localparam logic [6:0] IDX_PENDING = 7'h09;
    localparam logic [6:0] IDX_PORT_RDSEL = 7'h0A;
    localparam logic [6:0] IDX_RAM_FIRST = 7'h20;
    localparam logic [6:0] IDX_RAM_LAST = 7'h4F;
    localparam int RAM_DEPTH = 48;
    // field positions of the flag register
    localparam int FLAG_GB0 = 6;
    localparam int FLAG_WDT = 4;
    localparam int FLAG_PD = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_DC = 1;
    localparam int FLAG_C = 0;
    localparam logic [7:0] FLAGS_MASK = 8'h5F;
    // enable and pending bit positions
    localparam int IRQ_PULSE_GEN = 7;
    localparam int IRQ_TIMER2 = 6;
    localparam int IRQ_TIMER0 = 4;
    localparam int IRQ_WAKEUP = 3;
    localparam int IRQ_PIN_B = 2;
    localparam int IRQ_PIN_A = 0;
    localparam logic [7:0] IRQ_MASK = 8'hDD;
    // reset values
    localparam logic [7:0] TIMER0_RST = 8'h00;
    localparam logic [7:0] PCL_RST = 8'h00;
    localparam logic [7:0] POINTER_RST = 8'h00;
    localparam logic [4:0] PORTA_LOW_RST = 5'h1F;
    localparam logic PIN7_MODE_RST = 1'b1;
    localparam logic [7:0] IRQ_EN_RST = 8'h00;
    localparam logic [7:0] PENDING_RST = 8'h00;

    typedef struct packed {
        logic pulse_gen;
        logic timer2;
        logic wakeup;
        logic timer0_tick;
    } cpr_events_t;

    typedef struct packed {
        logic update;
        logic zero;
        logic half_carry;
        logic carry;
    } cpr_alu_flags_t;
endpackage

// file: hdl/cpr_core_plane.sv
// core plane register bank: window, timer0, pc low, flags, pointer, port a, irq enables
//
// Contract
// - offset 0x00 redirects through indirect pointer
// - pointer low seven bits address indirectly
// - full pointer byte is table-read low byte
// - pc low byte readable, writable, resets zero
// - watchdog and power-down flags read-only; gb0 stored
// - half-byte carry flag writable, resets zero
// - carry flag writable, resets zero
// - pin7 mode bit: 0 open-drain, 1 input
// - bit7 read gives pin or latch
// - bits 4:0 read give pins or latch
// - bits 4:0 write output latch, reset 1F
// - enables for pulse gen, timer2, timer0
// - wakeup timer enable at bit 3
// - pin enables at bits 2 and 0
// - timer0 count readable, writable, resets zero
// - read select bit 0 at index 0x0A: 1 reads latch, 0 reads pins
// - hardware sets pending, write 0 clears
// - pin7 falling edge raises its event
`timescale 1ns/10ps
`default_nettype none
module cpr_core_plane
    import cpr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cpr_events_t events,
    input wire cpr_alu_flags_t alu_flags,
    input wire logic watchdog_expired_in,
    input wire logic power_down_in,
    input wire logic [7:0] port_a_pin_in,
    output logic [4:0] port_a_out,
    output logic port_a_bit7_pin_out,
    output logic port_a_bit7_pin_oe_n,
    output logic [7:0] program_counter_low_byte,
    output logic [7:0] table_read_pointer_low,
    output logic [7:0] pending_flags,
    output logic irq_request
);
    logic [7:0] timer0_count;
    logic [7:0] indirect_pointer;
    logic [7:0] core_flag_register;
    logic [4:0] port_a_latch;
    logic pin7_latch_or_mode;
    logic [7:0] irq_enables;
    logic port_read_latch;
    logic [7:0] ram [RAM_DEPTH];
    logic [7:0] pin_prev;
    // no edge is reported until one real pin sample has been taken after reset
    logic edge_armed;
    logic [6:0] addr_idx;
    logic [6:0] eff_idx;
    logic setup;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] next_read;
    logic next_err;
    logic [7:0] port_view;
    logic [7:0] set_pend;
    logic [7:0] keep_pend;
    logic timer0_wr;

    function automatic logic is_ram(input logic [6:0] idx);
        return (idx >= IDX_RAM_FIRST) && (idx <= IDX_RAM_LAST);
    endfunction

    function automatic logic [5:0] ram_slot(input logic [6:0] idx);
        logic [6:0] off;
        off = idx - IDX_RAM_FIRST;
        return off[5:0];
    endfunction

    function automatic logic hit(input logic [6:0] idx, input logic [6:0] reg_idx);
        return idx == reg_idx;
    endfunction

    assign addr_idx = paddr[8:2];
    assign eff_idx = hit(addr_idx, IDX_WINDOW) ? indirect_pointer[6:0] : addr_idx;
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite & pstrb[0];
    assign wdata = pwdata[7:0];
    assign pready = 1'b1;

    // pins or output latch depending on read kind
    always_comb begin
        if (port_read_latch) begin
            port_view = {pin7_latch_or_mode, 2'b00, port_a_latch};
        end else begin
            port_view = {port_a_pin_in[7], 2'b00, port_a_pin_in[4:0]};
        end
    end

    // read mux over the effective index
    always_comb begin
        next_read = 8'h00;
        next_err = 1'b0;
        case (eff_idx)
            IDX_WINDOW: next_read = 8'h00;
            IDX_TIMER0: next_read = timer0_count;
            IDX_PCL: next_read = program_counter_low_byte;
            IDX_FLAGS: next_read = core_flag_register & FLAGS_MASK;
            IDX_POINTER: next_read = indirect_pointer;
            IDX_PORTA: next_read = port_view;
            IDX_IRQ_EN: next_read = irq_enables & IRQ_MASK;
            IDX_PENDING: next_read = pending_flags;
            IDX_PORT_RDSEL: next_read = {7'h00, port_read_latch};
            default: begin
                if (is_ram(eff_idx)) begin
                    next_read = ram[ram_slot(eff_idx)];
                end else begin
                    next_err = 1'b1;
                end
            end
        endcase
    end

    // read data and error captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= {24'h00_0000, next_read};
            pslverr <= next_err;
        end
    end

    assign timer0_wr = wr && hit(eff_idx, IDX_TIMER0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer0_count <= TIMER0_RST;
        end else if (timer0_wr) begin
            timer0_count <= wdata;
        end else if (events.timer0_tick) begin
            timer0_count <= timer0_count + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_counter_low_byte <= PCL_RST;
        end else if (wr && hit(eff_idx, IDX_PCL)) begin
            program_counter_low_byte <= wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            indirect_pointer <= POINTER_RST;
        end else if (wr && hit(eff_idx, IDX_POINTER)) begin
            indirect_pointer <= wdata;
        end
    end

    assign table_read_pointer_low = indirect_pointer;

    // flag register: status inputs tracked, arithmetic flags writable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_flag_register <= 8'h00;
        end else begin
            core_flag_register[FLAG_WDT] <= watchdog_expired_in;
            core_flag_register[FLAG_PD] <= power_down_in;
            if (wr && hit(eff_idx, IDX_FLAGS)) begin
                core_flag_register[FLAG_GB0] <= wdata[FLAG_GB0];
                core_flag_register[FLAG_Z] <= wdata[FLAG_Z];
                core_flag_register[FLAG_DC] <= wdata[FLAG_DC];
                core_flag_register[FLAG_C] <= wdata[FLAG_C];
            end else if (alu_flags.update) begin
                core_flag_register[FLAG_Z] <= alu_flags.zero;
                core_flag_register[FLAG_DC] <= alu_flags.half_carry;
                core_flag_register[FLAG_C] <= alu_flags.carry;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_latch <= PORTA_LOW_RST;
            pin7_latch_or_mode <= PIN7_MODE_RST;
        end else if (wr && hit(eff_idx, IDX_PORTA)) begin
            port_a_latch <= wdata[4:0];
            pin7_latch_or_mode <= wdata[7];
        end
    end

    assign port_a_out = port_a_latch;
    // bit 7 open-drain: drive low when mode bit is 0, release otherwise
    assign port_a_bit7_pin_out = 1'b0;
    assign port_a_bit7_pin_oe_n = pin7_latch_or_mode;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_read_latch <= 1'b0;
        end else if (wr && hit(eff_idx, IDX_PORT_RDSEL)) begin
            port_read_latch <= wdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enables <= IRQ_EN_RST;
        end else if (wr && hit(eff_idx, IDX_IRQ_EN)) begin
            irq_enables <= wdata & IRQ_MASK;
        end
    end

    // previous pin samples for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev <= 8'hFF;
            edge_armed <= 1'b0;
        end else begin
            pin_prev <= port_a_pin_in;
            edge_armed <= 1'b1;
        end
    end

    always_comb begin
        set_pend = 8'h00;
        set_pend[IRQ_PULSE_GEN] = events.pulse_gen;
        set_pend[IRQ_TIMER2] = events.timer2;
        set_pend[IRQ_TIMER0] = events.timer0_tick && !timer0_wr
            && (timer0_count == 8'hFF);
        set_pend[IRQ_WAKEUP] = events.wakeup;
        set_pend[IRQ_PIN_B] = edge_armed & pin_prev[7] & ~port_a_pin_in[7];
        set_pend[IRQ_PIN_A] = edge_armed & pin_prev[0] & ~port_a_pin_in[0];
        keep_pend = (wr && hit(eff_idx, IDX_PENDING)) ? wdata : 8'hFF;
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_flags <= PENDING_RST;
        end else begin
            pending_flags <= ((pending_flags & keep_pend) | set_pend) & IRQ_MASK;
        end
    end

    always_ff @(posedge pclk) begin
        if (wr && is_ram(eff_idx)) begin
            ram[ram_slot(eff_idx)] <= wdata;
        end
    end

    assign irq_request = |(pending_flags & irq_enables);
endmodule // cpr_core_plane
`default_nettype wire

// file: tb/cpr_core_plane_sva.sv
// assertion checker for the core plane register bank
`timescale 1ns/10ps
`default_nettype none
module cpr_chk
    import cpr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic watchdog_expired_in,
    input wire logic power_down_in,
    input wire logic [7:0] port_a_pin_in,
    input wire logic [4:0] port_a_out,
    input wire logic port_a_bit7_pin_out,
    input wire logic port_a_bit7_pin_oe_n,
    input wire logic [7:0] program_counter_low_byte,
    input wire logic [7:0] table_read_pointer_low,
    input wire logic [7:0] pending_flags,
    input wire logic irq_request
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    assign wr = psel && penable && pwrite && pstrb[0];
    property p_pcl;
        wr && paddr[8:2] == IDX_PCL |=> program_counter_low_byte == $past(pwdata[7:0]);
    endproperty
    a_pcl: assert property (p_pcl)
        else $error("pc low write lost");
    property p_ptr;
        wr && paddr[8:2] == IDX_POINTER |=> table_read_pointer_low == $past(pwdata[7:0]);
    endproperty
    a_ptr: assert property (p_ptr)
        else $error("pointer write lost");
    property p_port;
        wr && paddr[8:2] == IDX_PORTA |=> port_a_out == $past(pwdata[4:0]);
    endproperty
    a_port: assert property (p_port)
        else $error("port latch write lost");
    property p_mode;
        wr && paddr[8:2] == IDX_PORTA |-> ##1 port_a_bit7_pin_oe_n == $past(pwdata[7]);
    endproperty
    a_mode: assert property (p_mode)
        else $error("pin7 mode wrong");
    property p_pinlo;
        !port_a_bit7_pin_oe_n |-> !port_a_bit7_pin_out;
    endproperty
    a_pinlo: assert property (p_pinlo)
        else $error("pin7 not driven low");
    property p_flg;
        psel && !penable && paddr[8:2] == IDX_FLAGS |-> ##1 !prdata[7] && !prdata[5]
            && prdata[4:3] == {$past(watchdog_expired_in, 2), $past(power_down_in, 2)};
    endproperty
    a_flg: assert property (p_flg)
        else $error("flag read wrong");
    property p_pmask;
        (pending_flags & ~IRQ_MASK) == 8'h00;
    endproperty
    a_pmask: assert property (p_pmask)
        else $error("reserved pending bit set");
    property p_irq;
        irq_request |-> |pending_flags;
    endproperty
    a_irq: assert property (p_irq)
        else $error("request without pending");
    property p_fall;
        $fell(port_a_pin_in[7]) |=> pending_flags[IRQ_PIN_B];
    endproperty
    a_fall: assert property (p_fall)
        else $error("pin7 fall missed");
    c_pcl: cover property (wr && paddr[8:2] == IDX_PCL);
    c_fall: cover property ($fell(port_a_pin_in[7]));
    c_irq: cover property (irq_request);
endmodule // cpr_chk
bind cpr_core_plane cpr_chk u_chk (.*);
`default_nettype wire

// file: tb/tb_cpr_core_plane.sv
// self-checking testbench for the core plane register bank
`timescale 1ns/10ps
`default_nettype none
module tb_cpr_core_plane
    import cpr_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_request;
    logic watchdog_expired_in, power_down_in, port_a_bit7_pin_out, port_a_bit7_pin_oe_n;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [7:0] port_a_pin_in, program_counter_low_byte, table_read_pointer_low, pending_flags;
    logic [4:0] port_a_out;
    cpr_events_t events;
    cpr_alu_flags_t alu_flags;
    int miscompares, checks_done;
    // index, write value, read-back value
    logic [7:0] rows [6][3] = '{'{8'h01, 8'hA5, 8'hA5}, '{8'h02, 8'h5A, 8'h5A},
        '{8'h03, 8'hFF, 8'h47}, '{8'h04, 8'h83, 8'h83}, '{8'h08, 8'h22, 8'h00},
        '{8'h08, 8'hFF, 8'hDD}};
    cpr_core_plane uut (.*);
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i[6:0], 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {events, alu_flags, watchdog_expired_in, power_down_in} = '0;
        pstrb = 4'hF;
        port_a_pin_in = 8'hFF;
        miscompares = 0;
        checks_done = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            xfer(1'b1, rows[i][0], rows[i][1]);
            xfer(1'b0, rows[i][0], 8'h00);
            chk(rd, rows[i][2]);
        end
        $display("register rows done");
        xfer(1'b1, 8'h04, 8'h82);
        chk(table_read_pointer_low, 8'h82);
        xfer(1'b1, 8'h00, 8'h77);
        chk(program_counter_low_byte, 8'h77);
        xfer(1'b0, 8'h00, 8'h00);
        chk(rd, 8'h77);
        xfer(1'b1, 8'h05, 8'h8A);
        chk({port_a_bit7_pin_oe_n, port_a_out}, 6'h2A);
        @(posedge pclk) port_a_pin_in <= 8'h93;
        xfer(1'b0, 8'h05, 8'h00);
        chk(rd, 8'h93);
        xfer(1'b1, 8'h0A, 8'h01);
        xfer(1'b0, 8'h05, 8'h00);
        chk(rd, 8'h8A);
        xfer(1'b1, 8'h05, 8'h00);
        chk({port_a_bit7_pin_oe_n, port_a_bit7_pin_out}, 2'b00);
        $display("window and port done");
        @(posedge pclk) port_a_pin_in <= 8'h13;
        repeat (2) @(posedge pclk);
        #1;
        chk({irq_request, pending_flags}, 9'h104);
        xfer(1'b1, 8'h09, 8'h04);
        chk(pending_flags, 8'h04);
        xfer(1'b1, 8'h09, 8'h00);
        chk({irq_request, pending_flags}, 9'h000);
        xfer(1'b1, 8'h01, 8'hFF);
        @(posedge pclk) events <= 4'h1;
        alu_flags <= 4'h8;
        port_a_pin_in <= 8'h12;
        @(posedge pclk) events <= 4'h0;
        alu_flags <= 4'h0;
        #1;
        chk({irq_request, pending_flags}, 9'h111);
        xfer(1'b0, 8'h01, 8'h00);
        chk(rd, 8'h00);
        xfer(1'b0, 8'h03, 8'h00);
        chk(rd, 8'h40);
        xfer(1'b1, 8'h09, 8'h00);
        $display("timer and alu events done");
        @(posedge pclk) watchdog_expired_in <= 1'b1;
        power_down_in <= 1'b1;
        repeat (2) @(posedge pclk);
        xfer(1'b0, 8'h03, 8'h00);
        chk(rd, 8'h58);
        xfer(1'b1, 8'h03, 8'h00);
        xfer(1'b0, 8'h03, 8'h00);
        chk(rd, 8'h18);
        xfer(1'b0, 8'h06, 8'h00);
        chk({pslverr, rd}, 33'h100000000);
        $display("events and flags done");
        @(posedge pclk) watchdog_expired_in <= 1'b0;
        power_down_in <= 1'b0;
        presetn <= 1'b0;
        @(posedge pclk) #1;
        chk({port_a_out, port_a_bit7_pin_oe_n, program_counter_low_byte, pending_flags,
            irq_request}, 23'h7E0000);
        @(posedge pclk) presetn <= 1'b1;
        foreach (rows[i]) begin
            xfer(1'b0, rows[i][0], 8'h00);
            chk(rd, 8'h00);
        end
        chk(pending_flags, 8'h00);
        $display("reset values done");
        tally_and_finish();
    end
endmodule // tb_cpr_core_plane
`default_nettype wire
